// ==== watchdog_unit.sv ====
// Watchdog and interval timer with a plain register port
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_unit_map.svh"

module watchdog_unit (
  input  wire logic                           mclk,
  input  wire logic                           rst,
  input  wire watchdog_unit_pkg::bus_req_t    bus,
  output logic [7:0]                          rdata,
  input  wire logic                           lf_clk,
  input  wire watchdog_unit_pkg::power_mode_t power_mode,
  output logic                                sys_reset_req,
  output logic                                irq
);

  watchdog_unit_pkg::wdu_state_t st;
  watchdog_unit_pkg::wdu_state_t next_st;

  logic        wr_ctrl;
  logic        wr_irq;
  logic        rd_ctrl;
  logic        rd_irq;
  logic [3:0]  key;
  logic        lf_rise;
  logic        lf_edge;
  logic        halted;
  logic        expire;
  logic [14:0] last;

  assign wr_ctrl = bus.wr && (bus.addr == `WDU_CTRL_OFS);
  assign wr_irq  = bus.wr && (bus.addr == `WDU_IRQ_OFS);
  assign rd_ctrl = bus.rd && (bus.addr == `WDU_CTRL_OFS);
  assign rd_irq  = bus.rd && (bus.addr == `WDU_IRQ_OFS);
  assign key     = bus.wdata[`WDU_CLR_HI:`WDU_CLR_LO];

  // Low-speed level arrives synchronous, so one history bit suffices
  assign lf_rise = lf_clk && !st.lf_prev;
  assign lf_edge = lf_clk != st.lf_prev;

  assign halted = (power_mode == watchdog_unit_pkg::power_mode_two) ||
                  (power_mode == watchdog_unit_pkg::power_mode_three);

  always_comb begin
    case (st.intv)
      2'h0:    last = `WDU_LAST_64;
      2'h1:    last = `WDU_LAST_512;
      2'h2:    last = `WDU_LAST_8192;
      default: last = `WDU_LAST_32768;
    endcase
  end

  // Interval shortened below count still expires on next step
  assign expire = st.en && !halted && lf_rise && (st.cnt >= last);

  always_comb begin
    next_st = st;
    next_st.lf_prev = lf_clk;
    next_st.rdata = 8'h00;

    // Counter steps only on the low-speed rising edge
    if (st.en && !halted && lf_rise) begin
      next_st.cnt = expire ? 15'h0000 : st.cnt + 15'h0001;
    end
    // Pending wake reset lapses at the next step
    if (st.en && !halted && lf_rise) begin
      next_st.pm1_pend = 1'b0;
    end
    if (halted) begin
      next_st.cnt = 15'h0000;
      next_st.armed = 1'b0;
      next_st.pm1_pend = 1'b0;
    end

    if (expire && !st.mode) begin
      if (power_mode == watchdog_unit_pkg::power_mode_one) begin
        next_st.pm1_pend = 1'b1;
      end else begin
        next_st.reset_req = 1'b1;
      end
    end
    // Wake from power mode one right at expiry resets at once
    if (st.pm1_pend && !st.mode &&
        power_mode == watchdog_unit_pkg::power_mode_active) begin
      next_st.reset_req = 1'b1;
    end

    // Key window closes at the next low-speed edge
    if (lf_edge) begin
      next_st.armed = 1'b0;
    end

    if (wr_ctrl) begin
      next_st.intv = bus.wdata[`WDU_INT_HI:`WDU_INT_LO];
      if (st.en && !st.mode) begin
        next_st.en = 1'b1;
      end else begin
        next_st.mode = bus.wdata[`WDU_MODE_BIT];
        next_st.en = bus.wdata[`WDU_EN_BIT];
        if (!st.en && bus.wdata[`WDU_EN_BIT]) begin
          next_st.cnt = 15'h0000;
        end
      end
      if (st.en && !st.mode) begin
        if (key == `WDU_KEY_FIRST) begin
          next_st.armed = 1'b1;
        end else begin
          next_st.armed = 1'b0;
        end
        // A late or wrong second key leaves the count running
        if (key == `WDU_KEY_SECOND && st.armed && !lf_edge) begin
          next_st.cnt = 15'h0000;
          next_st.pm1_pend = 1'b0;
        end
      end else if (st.en && st.mode && bus.wdata[`WDU_CLR_LO]) begin
        next_st.cnt = 15'h0000;
      end
    end

    if (wr_irq) begin
      next_st.irq_en = bus.wdata[`WDU_IE_BIT];
      if (bus.wdata[`WDU_FLAG_BIT]) begin
        next_st.flag = 1'b0;
      end
    end
    // Expiry set wins over a same-cycle clear; no reset in timer mode
    if (expire && st.mode) begin
      next_st.flag = 1'b1;
    end

    if (rd_ctrl) begin
      next_st.rdata = {4'h0, st.en, st.mode, st.intv};
    end else if (rd_irq) begin
      next_st.rdata = {6'h00, st.irq_en, st.flag};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign sys_reset_req = st.reset_req;
  assign irq = st.flag && st.irq_en;

endmodule
`default_nettype wire

// ==== watchdog_unit_map.svh ====
// Register offsets, field positions and counts of the watchdog unit
`ifndef WATCHDOG_UNIT_MAP_SVH
`define WATCHDOG_UNIT_MAP_SVH

`define WDU_ADDR_W        8
`define WDU_CTRL_OFS      8'h00
`define WDU_IRQ_OFS       8'h04

`define WDU_CLR_HI        7
`define WDU_CLR_LO        4
`define WDU_EN_BIT        3
`define WDU_MODE_BIT      2
`define WDU_INT_HI        1
`define WDU_INT_LO        0
`define WDU_FLAG_BIT      0
`define WDU_IE_BIT        1

`define WDU_KEY_FIRST     4'ha
`define WDU_KEY_SECOND    4'h5

`define WDU_CNT_W         15
`define WDU_LAST_64       15'h003f
`define WDU_LAST_512      15'h01ff
`define WDU_LAST_8192     15'h1fff
`define WDU_LAST_32768    15'h7fff

`endif

// ==== watchdog_unit_pkg.sv ====
// Types shared by the watchdog unit and its users
package watchdog_unit_pkg;

  typedef enum logic [1:0] {
    power_mode_active,
    power_mode_one,
    power_mode_two,
    power_mode_three
  } power_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic        en;
    logic        mode;
    logic [1:0]  intv;
    logic        irq_en;
    logic        flag;
    logic [14:0] cnt;
    logic        armed;
    logic        lf_prev;
    logic        pm1_pend;
    logic        reset_req;
    logic [7:0]  rdata;
  } wdu_state_t;

endpackage

// ==== watchdog_unit_sva.sv ====
// Port checker for the watchdog unit
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_unit_map.svh"
module watchdog_unit_sva (
  input wire logic                           mclk,
  input wire logic                           rst,
  input wire watchdog_unit_pkg::bus_req_t    bus,
  input wire logic [7:0]                     rdata,
  input wire logic                           lf_clk,
  input wire watchdog_unit_pkg::power_mode_t power_mode,
  input wire logic                           sys_reset_req,
  input wire logic                           irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_rd_other;
    bus.rd && bus.addr != `WDU_CTRL_OFS && bus.addr != `WDU_IRQ_OFS;
  endsequence
  sequence s_flag_clr;
    bus.wr && bus.addr == `WDU_IRQ_OFS && bus.wdata[0];
  endsequence
  AST_RD_IDLE: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("rdata not idle");
  AST_HIDDEN: assert property (s_rd_other |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_START: assert property ($fell(rst) |-> !sys_reset_req && !irq)
    else $error("outputs active after reset");
  AST_RST_STICKY: assert property (sys_reset_req |=> sys_reset_req)
    else $error("reset request dropped");
  AST_RST_ACTIVE: assert property ($rose(sys_reset_req) |->
    $past(power_mode) == watchdog_unit_pkg::power_mode_active)
    else $error("reset request outside active mode");
  AST_NO_BOTH: assert property (irq |-> !sys_reset_req)
    else $error("irq and reset together");
  AST_IRQ_DROP: assert property ($fell(irq) |->
    $past(bus.wr && bus.addr == `WDU_IRQ_OFS))
    else $error("irq fell without write");
  AST_FLAG_CLR: assert property (s_flag_clr |=> !irq)
    else $error("flag clear ignored");
endmodule
bind watchdog_unit watchdog_unit_sva sva (.mclk(mclk), .rst(rst),
  .bus(bus), .rdata(rdata), .lf_clk(lf_clk), .power_mode(power_mode),
  .sys_reset_req(sys_reset_req), .irq(irq));
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the watchdog unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                           mclk = 1'b0;
  logic                           rst = 1'b1;
  watchdog_unit_pkg::bus_req_t    bus = '0;
  logic [7:0]                     rdata;
  logic                           lf_on = 1'b1;
  logic [2:0]                     lfc = 3'h0;
  watchdog_unit_pkg::power_mode_t pm = watchdog_unit_pkg::power_mode_active;
  logic                           sys_reset_req;
  logic                           irq;
  int                             n_mismatch = 0;
  int                             compares = 0;
  int                             cyc = 0;
  watchdog_unit dut (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
    .lf_clk(lfc[2]), .power_mode(pm), .sys_reset_req(sys_reset_req),
    .irq(irq));
  always #25 mclk = ~mclk;
  // Slow clock frozen during kick key writes so no edge splits the pair
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (lf_on)
      lfc <= lfc + 3'h1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize();
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, s);
    compares++;
    if (s !== e) begin
      $display("ERROR %s exp %h got %h", nm, e, s);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge mclk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask
  task automatic kick(input logic [3:0] k);
    lf_on <= 1'b0;
    wr(8'h00, 8'ha8);
    wr(8'h00, {k, 4'h8});
    lf_on <= 1'b1;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h08, 8'h00);
    wr(8'h04, 8'h02);
    wr(8'h00, 8'h0c);
    repeat (480) @(posedge mclk);
    chk("irq", 8'h00, irq);
    repeat (64) @(posedge mclk);
    chk("irq", 8'h01, irq);
    chk("rst", 8'h00, sys_reset_req);
    rd(8'h04, 8'h03);
    wr(8'h04, 8'h03);
    repeat (3) begin
      repeat (320) @(posedge mclk);
      wr(8'h00, 8'h1c);
    end
    chk("irq", 8'h00, irq);
    repeat (320) @(posedge mclk);
    wr(8'h00, 8'h04);
    repeat (600) @(posedge mclk);
    rd(8'h00, 8'h04);
    wr(8'h00, 8'h0c);
    repeat (480) @(posedge mclk);
    chk("irq", 8'h00, irq);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h03);
    wr(8'h00, 8'h08);
    wr(8'h00, 8'h04);
    wr(8'h00, 8'h09);
    rd(8'h00, 8'h09);
    repeat (4) begin
      kick(4'h5);
      repeat (320) @(posedge mclk);
    end
    pm <= watchdog_unit_pkg::power_mode_two;
    repeat (800) @(posedge mclk);
    pm <= watchdog_unit_pkg::power_mode_active;
    rd(8'h00, 8'h08);
    repeat (320) @(posedge mclk);
    chk("rst", 8'h00, sys_reset_req);
    pm <= watchdog_unit_pkg::power_mode_one;
    repeat (320) @(posedge mclk);
    chk("rst", 8'h00, sys_reset_req);
    pm <= watchdog_unit_pkg::power_mode_active;
    kick(4'h3);
    wr(8'h00, 8'ha8);
    repeat (8) @(posedge mclk);
    wr(8'h00, 8'h58);
    repeat (400) @(posedge mclk);
    chk("rst", 8'h01, sys_reset_req);
    chk("irq", 8'h00, irq);
    summarize();
  end
endmodule
`default_nettype wire
